/* File: design/srb_consts.svh */
// Register indices, reset values, value ranges and answer codes of the configuration bank.
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
// Register indices as seen by the host command.
`define SRB_IDX_NET_ID_HI   8'hbc
`define SRB_IDX_NET_ID_LO   8'hbd
`define SRB_IDX_PAN_ID_HI   8'hbe
`define SRB_IDX_PAN_ID_LO   8'hbf
`define SRB_IDX_MAC_ID_HI   8'hc0
`define SRB_IDX_MAC_ID_LO   8'hc1
`define SRB_IDX_BEACON      8'hc2
`define SRB_IDX_NODE_KIND   8'hc3
`define SRB_IDX_SECURITY    8'hc4
`define SRB_IDX_TAG_INTV    8'he6
`define SRB_IDX_LED_CLAIM   8'he7
`define SRB_IDX_FLASH_OK    8'he8
`define SRB_IDX_SLEEP_EN    8'he9
`define SRB_IDX_SLEEP_BASE  8'hea
`define SRB_IDX_SER_TAG     8'hec
`define SRB_IDX_ADC_REF     8'hf2
`define SRB_IDX_IO_FUNC     8'hf4
`define SRB_IDX_IO_DEFAULT  8'hf5
`define SRB_IDX_LOADER_DIS  8'hf6
// Number of storage slots.
`define SRB_SLOTS           19
// Reset values: the zero default and those that differ from it.
`define SRB_RST_ZERO        8'h00
`define SRB_RST_SECURITY    8'hff
`define SRB_RST_LED_CLAIM   8'h01
`define SRB_RST_SLEEP_BASE  8'h02
`define SRB_RST_IO_DEFAULT  8'hff
// Accepted value ranges.
`define SRB_MIN_ANY         8'h00
`define SRB_MAX_ANY         8'hff
`define SRB_MAX_FLAG        8'h01
`define SRB_MIN_SLEEP_BASE  8'h01
`define SRB_MAX_SLEEP_BASE  8'h28
`define SRB_MAX_SER_TAG     8'h04
`define SRB_MAX_ADC_REF     8'h02
// Answer codes; zero marks success.
`define SRB_ANS_OK          8'h00
`define SRB_ERR_COMMAND     8'h64
`define SRB_ERR_REGISTER    8'h65
`define SRB_ERR_VALUE       8'h66
`endif

/* File: design/srb_pkg.sv */
// Types shared by the configuration bank and its users.
package srb_pkg;
  // Command operation carried by a host request.
  typedef enum logic [1:0] {
    srb_op_read,
    srb_op_write,
    srb_op_bad_a,
    srb_op_bad_b
  } srb_op_t;

  // One host command, valid for one cycle.
  typedef struct packed {
    logic       valid;
    srb_op_t    op;
    logic [7:0] index;
    logic [7:0] value;
  } srb_cmd_t;

  // One answer, done for one cycle.
  typedef struct packed {
    logic       done;
    logic       failed;
    logic [7:0] code;
    logic [7:0] data;
  } srb_resp_t;

  // Settings that steer the rest of the module.
  typedef struct packed {
    logic       flash_permit;
    logic       loader_en;
    logic       led_claim;
    logic       sleep_en;
    logic [7:0] sleep_base;
    logic [7:0] tag_interval;
    logic [7:0] serial_tag;
    logic [7:0] adc_ref;
    logic [7:0] io_function;
    logic [7:0] io_default;
  } srb_ctrl_t;
endpackage

/* File: design/srb_bank.sv */
// Byte-wide configuration register bank answering host text commands.
// What this block does
// R1 - A command that succeeds answers with the success marker.
// R2 - Failures answer 100 bad command, 101 bad register, 102 bad value.
// R3 - Remote flash writes accepted only while the permit register holds 1.
// R4 - Bootloader enabled while its control register is 0, disabled at 1.
// R5 - I/O default state comes from its register, range 0 to 255, reset 255.
// R6 - Eight-bit registers load defaults at reset; out-of-range writes are rejected.
`timescale 1ns/100ps
`include "srb_consts.svh"

module srb_bank (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Host command and answer.
  input  wire srb_pkg::srb_cmd_t  cmd_i,
  output      srb_pkg::srb_resp_t resp_o,
  // Remote flash write request and verdict.
  input  wire logic              remote_wr_req,
  output      logic              remote_wr_grant,
  output      logic              remote_wr_deny,
  // Settings for the rest of the module.
  output      srb_pkg::srb_ctrl_t ctrl_o
);

  localparam int SLOTS = `SRB_SLOTS;

  // Maps a register index to its storage slot.
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    logic [5:0] s;
    s = 6'h3f;
    case (idx)
      `SRB_IDX_NET_ID_HI:  s = 6'd0;
      `SRB_IDX_NET_ID_LO:  s = 6'd1;
      `SRB_IDX_PAN_ID_HI:  s = 6'd2;
      `SRB_IDX_PAN_ID_LO:  s = 6'd3;
      `SRB_IDX_MAC_ID_HI:  s = 6'd4;
      `SRB_IDX_MAC_ID_LO:  s = 6'd5;
      `SRB_IDX_BEACON:     s = 6'd6;
      `SRB_IDX_NODE_KIND:  s = 6'd7;
      `SRB_IDX_SECURITY:   s = 6'd8;
      `SRB_IDX_TAG_INTV:   s = 6'd9;
      `SRB_IDX_LED_CLAIM:  s = 6'd10;
      `SRB_IDX_FLASH_OK:   s = 6'd11;
      `SRB_IDX_SLEEP_EN:   s = 6'd12;
      `SRB_IDX_SLEEP_BASE: s = 6'd13;
      `SRB_IDX_SER_TAG:    s = 6'd14;
      `SRB_IDX_ADC_REF:    s = 6'd15;
      `SRB_IDX_IO_FUNC:    s = 6'd16;
      `SRB_IDX_IO_DEFAULT: s = 6'd17;
      `SRB_IDX_LOADER_DIS: s = 6'd18;
      default:             s = 6'h3f;
    endcase
    return s;
  endfunction

  // Reset value of each slot.
  function automatic logic [7:0] rst_of(input int slot);
    logic [7:0] v;
    v = `SRB_RST_ZERO;
    case (slot)
      8:       v = `SRB_RST_SECURITY;
      10:      v = `SRB_RST_LED_CLAIM;
      13:      v = `SRB_RST_SLEEP_BASE;
      17:      v = `SRB_RST_IO_DEFAULT;
      default: v = `SRB_RST_ZERO;
    endcase
    return v;
  endfunction

  // Lowest accepted value of each slot.
  function automatic logic [7:0] min_of(input logic [5:0] slot);
    logic [7:0] v;
    v = `SRB_MIN_ANY;
    case (slot)
      6'd13:   v = `SRB_MIN_SLEEP_BASE;
      default: v = `SRB_MIN_ANY;
    endcase
    return v;
  endfunction

  // Highest accepted value of each slot.
  function automatic logic [7:0] max_of(input logic [5:0] slot);
    logic [7:0] v;
    v = `SRB_MAX_ANY;
    case (slot)
      6'd10, 6'd11, 6'd12, 6'd18: v = `SRB_MAX_FLAG;
      6'd13:                      v = `SRB_MAX_SLEEP_BASE;
      6'd14:                      v = `SRB_MAX_SER_TAG;
      6'd15:                      v = `SRB_MAX_ADC_REF;
      default:                    v = `SRB_MAX_ANY;
    endcase
    return v;
  endfunction

  logic [7:0]         regs_r [SLOTS];
  srb_pkg::srb_resp_t resp_r;
  srb_pkg::srb_resp_t resp_nxt;
  logic               grant_r;
  logic               deny_r;

  // Command decode.
  wire        op_known = (cmd_i.op == srb_pkg::srb_op_read) ||
                         (cmd_i.op == srb_pkg::srb_op_write);
  wire        is_write = cmd_i.op == srb_pkg::srb_op_write;
  wire [5:0]  slot     = slot_of(cmd_i.index);
  wire        hit      = slot != 6'h3f;
  wire [4:0]  slot_sel = hit ? slot[4:0] : 5'd0;
  wire [7:0]  rd_data  = regs_r[slot_sel];
  wire        range_ok = (cmd_i.value >= min_of(slot)) && (cmd_i.value <= max_of(slot)); // R6
  wire        wr_take  = cmd_i.valid && op_known && is_write && hit && range_ok;

  // Answer selection; errors ranked command, register, value.
  always_comb begin
    resp_nxt        = '0;
    resp_nxt.done   = cmd_i.valid;
    resp_nxt.code   = `SRB_ANS_OK; // R1
    if (!op_known) begin
      resp_nxt.failed = 1'b1;
      resp_nxt.code   = `SRB_ERR_COMMAND; // R2
    end else if (!hit) begin
      resp_nxt.failed = 1'b1;
      resp_nxt.code   = `SRB_ERR_REGISTER; // R2
    end else if (is_write && !range_ok) begin
      resp_nxt.failed = 1'b1;
      resp_nxt.code   = `SRB_ERR_VALUE; // R6
    end else if (is_write) begin
      resp_nxt.data   = cmd_i.value;
    end else begin
      resp_nxt.data   = rd_data;
    end
    if (!cmd_i.valid) begin
      resp_nxt = '0;
    end
  end

  // Register storage with its manufacturer defaults.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        regs_r[i] <= rst_of(i); // R6
      end
    end else if (wr_take) begin
      regs_r[slot_sel] <= cmd_i.value;
    end
  end

  // Answer register.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resp_r <= '0;
    end else begin
      resp_r <= resp_nxt;
    end
  end

  // Remote flash verdict, one cycle after the request.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end else begin
      grant_r <= remote_wr_req && (regs_r[11] == 8'h01); // R3
      deny_r  <= remote_wr_req && (regs_r[11] != 8'h01); // R3
    end
  end

  // Outputs taken from the flip-flops, the loader enable through an inverter.
  assign resp_o                = resp_r;
  assign remote_wr_grant       = grant_r;
  assign remote_wr_deny        = deny_r;
  assign ctrl_o.flash_permit   = regs_r[11][0];
  assign ctrl_o.loader_en      = ~regs_r[18][0]; // R4
  assign ctrl_o.led_claim      = regs_r[10][0];
  assign ctrl_o.sleep_en       = regs_r[12][0];
  assign ctrl_o.sleep_base     = regs_r[13];
  assign ctrl_o.tag_interval   = regs_r[9];
  assign ctrl_o.serial_tag     = regs_r[14];
  assign ctrl_o.adc_ref        = regs_r[15];
  assign ctrl_o.io_function    = regs_r[16];
  assign ctrl_o.io_default     = regs_r[17]; // R5

  // Checks on the answer and the settings.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Every command is answered exactly on the next edge.
  property p_answer_next;
    cmd_i.valid |=> resp_o.done;
  endproperty
  a_answer_next: assert property (p_answer_next) // R1
    else $error("command not answered on next cycle");

  // No answer without a command.
  property p_no_spurious;
    !cmd_i.valid |=> !resp_o.done;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // R1
    else $error("answer without command");

  // Good write answers success carrying the value.
  property p_write_ok;
    wr_take |=> resp_o.done && !resp_o.failed && resp_o.code == `SRB_ANS_OK &&
               resp_o.data == $past(cmd_i.value);
  endproperty
  a_write_ok: assert property (p_write_ok) // R1
    else $error("good write not answered with success");

  // Unknown operation gives code 100.
  property p_bad_command;
    cmd_i.valid && !op_known |=> resp_o.failed && resp_o.code == `SRB_ERR_COMMAND;
  endproperty
  a_bad_command: assert property (p_bad_command) // R2
    else $error("bad command code wrong");

  // Missing register gives code 101.
  property p_bad_register;
    cmd_i.valid && op_known && !hit |=> resp_o.failed && resp_o.code == `SRB_ERR_REGISTER;
  endproperty
  a_bad_register: assert property (p_bad_register) // R2
    else $error("bad register code wrong");

  // Out-of-range write gives 102 and leaves the stored value alone.
  property p_bad_value;
    cmd_i.valid && is_write && hit && !range_ok |=>
      resp_o.code == `SRB_ERR_VALUE && regs_r[$past(slot_sel)] == $past(rd_data);
  endproperty
  a_bad_value: assert property (p_bad_value) // R6
    else $error("out of range write not rejected");

  // Remote flash writes follow the permit register.
  property p_flash_gate;
    remote_wr_req |=> (remote_wr_grant == ($past(regs_r[11]) == 8'h01)) &&
                      (remote_wr_deny != remote_wr_grant);
  endproperty
  a_flash_gate: assert property (p_flash_gate) // R3
    else $error("remote flash verdict wrong");

  // Accepted write of 1 to the loader register disables the loader.
  property p_loader_off;
    wr_take && cmd_i.index == `SRB_IDX_LOADER_DIS && cmd_i.value == 8'h01 |=>
      !ctrl_o.loader_en ##1 !ctrl_o.loader_en || $past(wr_take);
  endproperty
  a_loader_off: assert property (p_loader_off) // R4
    else $error("bootloader not disabled");

  // I/O default state follows an accepted write.
  property p_io_default;
    wr_take && cmd_i.index == `SRB_IDX_IO_DEFAULT |=> ctrl_o.io_default == $past(cmd_i.value);
  endproperty
  a_io_default: assert property (p_io_default) // R5
    else $error("io default state not updated");

  // Read returns the stored value.
  property p_readback;
    cmd_i.valid && !is_write && op_known && hit |=> resp_o.data == $past(rd_data);
  endproperty
  a_readback: assert property (p_readback) // R1
    else $error("read returned wrong value");

  // A failed command carries no data.
  property p_fail_no_data;
    resp_o.done && resp_o.failed |-> resp_o.data == 8'h00;
  endproperty
  a_fail_no_data: assert property (p_fail_no_data) // R2
    else $error("failed answer carries data");

  // Success is marked by code zero, failure by one of the three error codes.
  property p_code_set;
    resp_o.done |-> (!resp_o.failed && resp_o.code == `SRB_ANS_OK) ||
                    (resp_o.failed && (resp_o.code == `SRB_ERR_COMMAND ||
                     resp_o.code == `SRB_ERR_REGISTER || resp_o.code == `SRB_ERR_VALUE));
  endproperty
  a_code_set: assert property (p_code_set) // R1
    else $error("answer code outside the defined set");

  // A read never changes the storage.
  property p_read_keeps;
    cmd_i.valid && op_known && !is_write && hit |=> regs_r[$past(slot_sel)] == $past(rd_data);
  endproperty
  a_read_keeps: assert property (p_read_keeps) // R6
    else $error("read changed a stored value");

  // Flash verdicts appear only after a request.
  property p_flash_quiet;
    !remote_wr_req |=> !remote_wr_grant && !remote_wr_deny;
  endproperty
  a_flash_quiet: assert property (p_flash_quiet) // R3
    else $error("flash verdict without request");

  // Flag registers never hold a value above one.
  property p_flag_range;
    regs_r[10] <= `SRB_MAX_FLAG && regs_r[11] <= `SRB_MAX_FLAG &&
    regs_r[12] <= `SRB_MAX_FLAG && regs_r[18] <= `SRB_MAX_FLAG;
  endproperty
  a_flag_range: assert property (p_flag_range) // R6
    else $error("flag register out of range");

  // Sleep base stays within its accepted range.
  property p_sleep_range;
    regs_r[13] >= `SRB_MIN_SLEEP_BASE && regs_r[13] <= `SRB_MAX_SLEEP_BASE;
  endproperty
  a_sleep_range: assert property (p_sleep_range) // R6
    else $error("sleep base out of range");

  // Main scenarios.
  c_write_then_read: cover property (wr_take ##1 cmd_i.valid && !is_write && hit);
  c_value_reject:    cover property (cmd_i.valid && is_write && hit && !range_ok);
  c_flash_granted:   cover property (remote_wr_req ##1 remote_wr_grant);
  c_loader_off:      cover property (!ctrl_o.loader_en);
  c_bad_command:     cover property (cmd_i.valid && !op_known);

endmodule // srb_bank

/* File: tb/srb_host_model.sv */
// Host model that issues configuration commands and collects their answers.
`timescale 1ns/100ps

module srb_host_model (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst_b,
  // Command out, answer in.
  output      srb_pkg::srb_cmd_t  cmd_o,
  input  wire srb_pkg::srb_resp_t resp_i
);
  // The command bus rests idle until the first request.
  initial cmd_o = '0;

  // One command: raise valid after an edge, hold it for the taking edge, take the answer after it.
  task automatic xfer(input srb_pkg::srb_op_t op, input logic [7:0] idx,
                      input logic [7:0] val, output srb_pkg::srb_resp_t rsp);
    @(posedge clock);
    #1;
    cmd_o = {1'b1, op, idx, val};
    @(posedge clock);
    #1;
    rsp = resp_i;
    // Released index and value show the inverse so that stale values are never mistaken for live ones.
    cmd_o.valid = 1'b0;
    cmd_o.index = ~idx;
    cmd_o.value = ~val;
  endtask
endmodule // srb_host_model

/* File: tb/tb.sv */
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps

module tb;
  logic               clock;
  logic               rst_b;
  srb_pkg::srb_cmd_t  cmd;
  srb_pkg::srb_resp_t resp;
  logic               req;
  logic               grant;
  logic               deny;
  srb_pkg::srb_ctrl_t ctrl;
  int                 fail_count;
  int                 n_tests;
  int                 cycles;
  logic [7:0]         idx_t [19];
  logic [7:0]         rst_t [19];
  logic [7:0]         max_t [19];

  srb_bank u_srb_bank (.clock(clock), .rst_b(rst_b), .cmd_i(cmd), .resp_o(resp),
    .remote_wr_req(req), .remote_wr_grant(grant), .remote_wr_deny(deny), .ctrl_o(ctrl));
  srb_host_model u_srb_host_model (.clock(clock), .rst_b(rst_b), .cmd_o(cmd), .resp_i(resp));

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // Cycle ceiling that cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end

  // Compares one byte.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one command and compares the whole answer.
  task automatic cmd_chk(input srb_pkg::srb_op_t op, input logic [7:0] idx,
                         input logic [7:0] val, input logic [7:0] code, input logic [7:0] data);
    srb_pkg::srb_resp_t r;
    u_srb_host_model.xfer(op, idx, val, r);
    chk({7'h00, r.done}, 8'h01);
    chk({7'h00, r.failed}, {7'h00, code != 8'h00});
    chk(r.code, code);
    chk(r.data, data);
  endtask

  // Pulses a remote flash request and checks the verdict one cycle later.
  task automatic flash(input logic exp);
    @(posedge clock);
    #1;
    req = 1'b1;
    @(posedge clock);
    #1;
    req = 1'b0;
    chk({6'h00, grant, deny}, {6'h00, exp, ~exp});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    req = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    idx_t = '{8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'he6,
              8'he7, 8'he8, 8'he9, 8'hea, 8'hec, 8'hf2, 8'hf4, 8'hf5, 8'hf6};
    rst_t = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
              8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    max_t = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
              8'h01, 8'h01, 8'h01, 8'h28, 8'h04, 8'h02, 8'hff, 8'hff, 8'h01};
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    // Settings straight after reset.
    chk({7'h00, ctrl.loader_en}, 8'h01);
    chk(ctrl.io_default, 8'hff);
    chk({7'h00, ctrl.flash_permit}, 8'h00);
    chk({7'h00, ctrl.led_claim}, 8'h01);
    chk({7'h00, ctrl.sleep_en}, 8'h00);
    chk(ctrl.sleep_base, 8'h02);
    chk(ctrl.tag_interval, 8'h00);
    chk(ctrl.serial_tag, 8'h00);
    chk(ctrl.adc_ref, 8'h00);
    chk(ctrl.io_function, 8'h00);
    flash(1'b0);
    // Every register reads its default.
    for (int i = 0; i < 19; i++) begin
      cmd_chk(srb_pkg::srb_op_read, idx_t[i], 8'h00, 8'h00, rst_t[i]);
    end
    // Top of range is kept, one above and the zero below sleep base are refused.
    for (int i = 0; i < 19; i++) begin
      cmd_chk(srb_pkg::srb_op_write, idx_t[i], max_t[i], 8'h00, max_t[i]);
      if (max_t[i] != 8'hff) begin
        cmd_chk(srb_pkg::srb_op_write, idx_t[i], max_t[i] + 8'h01, 8'h66, 8'h00);
      end
      if (i == 13) begin
        cmd_chk(srb_pkg::srb_op_write, idx_t[i], 8'h00, 8'h66, 8'h00);
      end
      cmd_chk(srb_pkg::srb_op_read, idx_t[i], 8'h00, 8'h00, max_t[i]);
    end
    chk({7'h00, ctrl.loader_en}, 8'h00);
    chk({7'h00, ctrl.flash_permit}, 8'h01);
    chk({7'h00, ctrl.led_claim}, 8'h01);
    chk({7'h00, ctrl.sleep_en}, 8'h01);
    chk(ctrl.sleep_base, 8'h28);
    chk(ctrl.tag_interval, 8'hff);
    chk(ctrl.serial_tag, 8'h04);
    chk(ctrl.adc_ref, 8'h02);
    chk(ctrl.io_function, 8'hff);
    chk(ctrl.io_default, 8'hff);
    flash(1'b1);
    cmd_chk(srb_pkg::srb_op_write, 8'he8, 8'h00, 8'h00, 8'h00);
    flash(1'b0);
    cmd_chk(srb_pkg::srb_op_write, 8'hf6, 8'h00, 8'h00, 8'h00);
    cmd_chk(srb_pkg::srb_op_write, 8'he7, 8'h00, 8'h00, 8'h00);
    chk({7'h00, ctrl.led_claim}, 8'h00);
    chk({7'h00, ctrl.loader_en}, 8'h01);
    cmd_chk(srb_pkg::srb_op_write, 8'hf5, 8'h5a, 8'h00, 8'h5a);
    chk(ctrl.io_default, 8'h5a);
    // Error codes and their priority.
    cmd_chk(srb_pkg::srb_op_bad_a, 8'hbc, 8'h00, 8'h64, 8'h00);
    cmd_chk(srb_pkg::srb_op_bad_b, 8'hbb, 8'h07, 8'h64, 8'h00);
    cmd_chk(srb_pkg::srb_op_read, 8'hbb, 8'h00, 8'h65, 8'h00);
    cmd_chk(srb_pkg::srb_op_read, 8'heb, 8'h00, 8'h65, 8'h00);
    cmd_chk(srb_pkg::srb_op_write, 8'hf7, 8'h09, 8'h65, 8'h00);
    cmd_chk(srb_pkg::srb_op_write, 8'hc5, 8'h00, 8'h65, 8'h00);
    cmd_chk(srb_pkg::srb_op_read, 8'hf5, 8'h00, 8'h00, 8'h5a);
    // A second reset in mid-run brings back the defaults.
    @(posedge clock);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    chk(ctrl.io_default, 8'hff);
    chk({7'h00, ctrl.loader_en}, 8'h01);
    chk({7'h00, ctrl.led_claim}, 8'h01);
    cmd_chk(srb_pkg::srb_op_read, 8'hf5, 8'h00, 8'h00, 8'hff);
    flash(1'b0);
    results();
  end
endmodule // tb
